// ### core/plx_pkg.sv
// ****************************************************
// port latch and crossbar control constants
// ****************************************************
package plx_pkg;

  // ****************************************************
  // register offsets on the special function register bus
  // ****************************************************
  localparam logic [7:0] PLX_PORT0_ADDR = 8'h80; // port0_pin_latch
  localparam logic [7:0] PLX_PORT1_ADDR = 8'h90; // port1 latch
  localparam logic [7:0] PLX_PORT2_ADDR = 8'ha0; // port2_pin_latch
  localparam logic [7:0] PLX_XBR2_ADDR = 8'he2; // crossbar_config_second

  // ****************************************************
  // reset values
  // ****************************************************
  localparam logic [7:0] PLX_PORT0_RST = 8'hff; // latches idle high
  localparam logic [7:0] PLX_PORT1_RST = 8'hff;
  localparam logic [7:0] PLX_PORT2_RST = 8'h01;
  localparam logic [7:0] PLX_XBR2_RST = 8'h00;

  // ****************************************************
  // field positions in crossbar_config_second
  // ****************************************************
  localparam int PLX_PU_DIS_BIT = 7; // weak_pullup_disable
  localparam int PLX_XBAR_EN_BIT = 6; // crossbar_enable
  localparam int PLX_TMR1_RT_BIT = 5; // timer1_input_route_en
  localparam int PLX_TMR0_RT_BIT = 4; // timer0_input_route_en
  localparam int PLX_ECLK_RT_BIT = 3; // counter_array_ext_clk_route_en
  localparam int PLX_CMSEL_LSB = 0; // compare_module_route_sel, 2 bits
  localparam logic [7:0] PLX_XBR2_WMASK = 8'hfb; // bit 2 unused

  // ****************************************************
  // pin counts and bit addressing
  // ****************************************************
  localparam int PLX_NPINS = 17; // port0 8, port1 8, port2 1
  localparam logic [7:0] PLX_PORT2_WMASK = 8'h01; // only one port2 pin
  localparam logic [7:0] PLX_BIT_BASE_MASK = 8'hf8; // bit address -> byte

endpackage : plx_pkg

// ### core/plx_pin_cell.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************
// one port pin: driver, pull-up and receiver gating
// ****************************************************
module plx_pin_cell (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic latch_bit, // port latch value for this pin
  input wire logic xbar_en, // crossbar enable
  input wire logic weak_pud, // global weak pull-up disable
  input wire logic periph_sel, // crossbar gave pin to a peripheral
  input wire logic periph_out, // peripheral drive value
  input wire logic push_pull, // 1 push-pull, 0 open-drain
  input wire logic digital_in, // 1 digital, 0 analog
  input wire logic pin_in, // raw pin level
  output logic pin_out_reg, // driven level
  output logic pin_oe_reg, // driver on
  output logic pin_pullup_reg, // weak pull-up on
  output logic pin_level // receiver level, 0 when analog
);

  logic drive_val; // value the pin should show
  logic oe_next;
  logic out_next;
  logic pu_next;

  // ****************************************************
  // combinational pin decision
  // ****************************************************
  always_comb begin
    // unassigned pins fall back to the latch
    drive_val = (xbar_en && periph_sel) ? periph_out : latch_bit;
    if (!digital_in || !xbar_en) begin
      // analog pins and a disabled crossbar never drive
      oe_next = 1'b0;
      out_next = 1'b0;
    end else if (push_pull) begin
      oe_next = 1'b1;
      out_next = drive_val;
    end else begin
      // open-drain only ever pulls low
      oe_next = ~drive_val;
      out_next = 1'b0;
    end
    // pull-up only on idle-high open-drain digital pins
    pu_next = ~weak_pud & digital_in & ~push_pull & ~oe_next;
  end

  // receiver disabled on analog pins, reads as zero
  assign pin_level = digital_in & pin_in;

  // ****************************************************
  // registered pin controls
  // ****************************************************
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pin_out_reg <= 1'b0;
      pin_oe_reg <= 1'b0;
      pin_pullup_reg <= 1'b0;
    end else begin
      pin_out_reg <= out_next;
      pin_oe_reg <= oe_next;
      pin_pullup_reg <= pu_next;
    end
  end

endmodule // plx_pin_cell
`default_nettype wire

// ### core/plx_port_latch.sv
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// - unassigned digital pins act as latch-driven I/O
// - three ports byte and bit addressable
// - write stores latch, latch drives pin
// - ordinary read returns sampled pin levels
// - read-modify-write reads latch, writes back
// - latch read for all listed modify ops
// - timer1 input routed only when bit set
// - counter clock input routed only when set
// - crossbar enable gates all routing
// - port drivers off while crossbar disabled
// - weak pull-up on open-drain non-low pins
// - analog pins: no pull-up, driver, receiver
module plx_port_latch
  import plx_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  // ****************************************************
  // special function register bus
  // ****************************************************
  input wire logic [7:0] sfr_addr, // byte address
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr, // byte write strobe
  input wire logic sfr_rd, // byte read strobe
  input wire logic [7:0] sfr_bit_addr, // bit address
  input wire logic sfr_bit_wdata,
  input wire logic sfr_bit_wr, // bit write strobe
  input wire logic sfr_bit_rd, // bit read strobe
  input wire logic sfr_rmw, // read is half of a modify op
  output logic [7:0] sfr_rdata_reg, // byte read data
  output logic sfr_bit_rdata_reg, // bit read data
  // ****************************************************
  // pins and pin configuration
  // ****************************************************
  input wire logic [16:0] pin_in,
  output logic [16:0] pin_out_reg,
  output logic [16:0] pin_oe_reg,
  output logic [16:0] pin_pullup_reg,
  input wire logic [16:0] port_output_mode_reg, // 1 push-pull
  input wire logic [16:0] port_input_mode_reg, // 1 digital
  input wire logic [16:0] periph_sel, // from priority decoder
  input wire logic [16:0] periph_out,
  // ****************************************************
  // routing enables to the priority decoder
  // ****************************************************
  output logic timer1_input_route_en_reg,
  output logic timer0_input_route_en_reg,
  output logic counter_array_ext_clk_route_en_reg,
  output logic [2:0] compare_module_route_reg, // one bit per module
  output logic crossbar_enable_reg,
  output logic weak_pullup_disable_reg
);

  // ****************************************************
  // storage
  // ****************************************************
  logic [7:0] port0_latch_reg;
  logic [7:0] port1_latch_reg;
  logic [7:0] port2_latch_reg;
  logic [7:0] xbr2_reg; // crossbar_config_second
  logic [16:0] latch_vec; // latches flattened to pins
  logic [16:0] pin_level; // receiver levels
  logic [23:0] level_pad; // pin levels padded to three bytes
  logic [23:0] latch_pad; // latches padded to three bytes
  logic [7:0] bit_base; // byte holding an addressed bit
  logic [2:0] bit_idx;
  logic [7:0] rdata_next;
  logic bit_rdata_next;

  assign latch_vec = {port2_latch_reg[0], port1_latch_reg, port0_latch_reg};
  assign level_pad = {7'h00, pin_level};
  assign latch_pad = {7'h00, latch_vec};
  assign bit_base = sfr_bit_addr & PLX_BIT_BASE_MASK;
  assign bit_idx = sfr_bit_addr[2:0];

  // ****************************************************
  // port latches, byte and bit writes
  // ****************************************************
  // byte write wins if the core ever issues both at once
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      port0_latch_reg <= PLX_PORT0_RST;
      port1_latch_reg <= PLX_PORT1_RST;
      port2_latch_reg <= PLX_PORT2_RST;
    end else if (sfr_wr) begin
      // modify ops write their result back here too
      case (sfr_addr)
        PLX_PORT0_ADDR: port0_latch_reg <= sfr_wdata;
        PLX_PORT1_ADDR: port1_latch_reg <= sfr_wdata;
        PLX_PORT2_ADDR: port2_latch_reg <= sfr_wdata & PLX_PORT2_WMASK;
        default: begin
          // other addresses belong elsewhere
        end
      endcase
    end else if (sfr_bit_wr) begin
      // bit move, clear and set land in one latch bit
      case (bit_base)
        PLX_PORT0_ADDR: port0_latch_reg[bit_idx] <= sfr_bit_wdata;
        PLX_PORT1_ADDR: port1_latch_reg[bit_idx] <= sfr_bit_wdata;
        PLX_PORT2_ADDR: begin
          if (bit_idx == 3'h0) begin
            port2_latch_reg[0] <= sfr_bit_wdata;
          end
        end
        default: begin
          // not a port bit
        end
      endcase
    end
  end

  // ****************************************************
  // crossbar_config_second
  // ****************************************************
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      xbr2_reg <= PLX_XBR2_RST;
    end else if (sfr_wr && sfr_addr == PLX_XBR2_ADDR) begin
      xbr2_reg <= sfr_wdata & PLX_XBR2_WMASK;
    end
  end

  // ****************************************************
  // read mux: pins normally, latch for modify ops
  // ****************************************************
  always_comb begin
    rdata_next = 8'h00; // unmapped reads as zero
    bit_rdata_next = 1'b0;
    case (sfr_addr)
      PLX_PORT0_ADDR: rdata_next = sfr_rmw ? port0_latch_reg : level_pad[7:0];
      PLX_PORT1_ADDR: rdata_next = sfr_rmw ? port1_latch_reg : level_pad[15:8];
      PLX_PORT2_ADDR: rdata_next = sfr_rmw ? port2_latch_reg : level_pad[23:16];
      PLX_XBR2_ADDR: rdata_next = xbr2_reg;
      default: rdata_next = 8'h00;
    endcase
    // jump-and-clear and bit modify ops see the latch
    case (bit_base)
      PLX_PORT0_ADDR: bit_rdata_next = sfr_rmw ? latch_pad[bit_idx] : level_pad[bit_idx];
      PLX_PORT1_ADDR: bit_rdata_next = sfr_rmw ? latch_pad[{2'b01, bit_idx}] : level_pad[{2'b01, bit_idx}];
      PLX_PORT2_ADDR: bit_rdata_next = sfr_rmw ? latch_pad[{2'b10, bit_idx}] : level_pad[{2'b10, bit_idx}];
      default: bit_rdata_next = 1'b0;
    endcase
  end

  // read data holds until the next read strobe
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sfr_rdata_reg <= 8'h00;
      sfr_bit_rdata_reg <= 1'b0;
    end else begin
      if (sfr_rd) begin
        sfr_rdata_reg <= rdata_next;
      end
      if (sfr_bit_rd) begin
        sfr_bit_rdata_reg <= bit_rdata_next;
      end
    end
  end

  // ****************************************************
  // routing enables, all gated by the crossbar enable
  // ****************************************************
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      timer1_input_route_en_reg <= 1'b0;
      timer0_input_route_en_reg <= 1'b0;
      counter_array_ext_clk_route_en_reg <= 1'b0;
      compare_module_route_reg <= 3'h0;
      crossbar_enable_reg <= 1'b0;
      weak_pullup_disable_reg <= 1'b0;
    end else begin
      crossbar_enable_reg <= xbr2_reg[PLX_XBAR_EN_BIT];
      weak_pullup_disable_reg <= xbr2_reg[PLX_PU_DIS_BIT];
      timer1_input_route_en_reg <= xbr2_reg[PLX_XBAR_EN_BIT] & xbr2_reg[PLX_TMR1_RT_BIT];
      timer0_input_route_en_reg <= xbr2_reg[PLX_XBAR_EN_BIT] & xbr2_reg[PLX_TMR0_RT_BIT];
      counter_array_ext_clk_route_en_reg <= xbr2_reg[PLX_XBAR_EN_BIT] & xbr2_reg[PLX_ECLK_RT_BIT];
      if (!xbr2_reg[PLX_XBAR_EN_BIT]) begin
        compare_module_route_reg <= 3'h0;
      end else begin
        // thermometer decode of the module count
        case (xbr2_reg[PLX_CMSEL_LSB +: 2])
          2'b00: compare_module_route_reg <= 3'h0;
          2'b01: compare_module_route_reg <= 3'h1;
          2'b10: compare_module_route_reg <= 3'h3;
          2'b11: compare_module_route_reg <= 3'h7;
          default: compare_module_route_reg <= 3'h0;
        endcase
      end
    end
  end

  // ****************************************************
  // per-pin cells
  // ****************************************************
  genvar gi;
  generate
    for (gi = 0; gi < PLX_NPINS; gi = gi + 1) begin : g_pin
      plx_pin_cell u_cell (
        .clock(clock),
        .sys_rst(sys_rst),
        .latch_bit(latch_vec[gi]),
        .xbar_en(xbr2_reg[PLX_XBAR_EN_BIT]),
        .weak_pud(xbr2_reg[PLX_PU_DIS_BIT]),
        .periph_sel(periph_sel[gi]),
        .periph_out(periph_out[gi]),
        .push_pull(port_output_mode_reg[gi]),
        .digital_in(port_input_mode_reg[gi]),
        .pin_in(pin_in[gi]),
        .pin_out_reg(pin_out_reg[gi]),
        .pin_oe_reg(pin_oe_reg[gi]),
        .pin_pullup_reg(pin_pullup_reg[gi]),
        .pin_level(pin_level[gi])
      );
    end
  endgenerate

endmodule // plx_port_latch
`default_nettype wire

// ### test/plx_port_latch_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************
// port latch and crossbar checker
// ****************************************************
module plx_port_latch_chk (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_rd,
  input wire logic sfr_rmw,
  input wire logic [7:0] sfr_rdata_reg,
  input wire logic [16:0] pin_in,
  input wire logic [16:0] pin_oe_reg,
  input wire logic [16:0] pin_pullup_reg,
  input wire logic [16:0] port_output_mode_reg,
  input wire logic [16:0] port_input_mode_reg,
  input wire logic timer1_input_route_en_reg,
  input wire logic timer0_input_route_en_reg,
  input wire logic counter_array_ext_clk_route_en_reg,
  input wire logic [2:0] compare_module_route_reg,
  input wire logic crossbar_enable_reg
);
  // one clock domain, so one default clock and disable
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  // drivers and routing gated by the crossbar enable
  property p_oe_off; !crossbar_enable_reg |-> pin_oe_reg == 17'h0; endproperty
  a_oe_off: assert property (p_oe_off) else $error("driver on with crossbar off");
  property p_route_off;
    !crossbar_enable_reg |-> {timer1_input_route_en_reg, timer0_input_route_en_reg,
      counter_array_ext_clk_route_en_reg, compare_module_route_reg} == 6'h0;
  endproperty
  a_route_off: assert property (p_route_off) else $error("route on with crossbar off");
  // module field decodes as a thermometer only
  property p_cmp_therm; compare_module_route_reg inside {3'h0, 3'h1, 3'h3, 3'h7}; endproperty
  a_cmp_therm: assert property (p_cmp_therm) else $error("bad module routing");
  // plain port0 read returns pins, analog pins as 0
  property p_pin_read;
    sfr_rd && sfr_addr == 8'h80 && !sfr_rmw |=> sfr_rdata_reg == 8'($past(pin_in) & $past(port_input_mode_reg));
  endproperty
  a_pin_read: assert property (p_pin_read) else $error("port0 read not pins");
  property p_port2_hi; sfr_rd && sfr_addr == 8'ha0 |=> sfr_rdata_reg[7:1] == 7'h0; endproperty
  a_port2_hi: assert property (p_port2_hi) else $error("port2 upper bits set");
  property p_cfg_bit2; sfr_rd && sfr_addr == 8'he2 |=> !sfr_rdata_reg[2]; endproperty
  a_cfg_bit2: assert property (p_cfg_bit2) else $error("unused config bit set");
  // pull-up never on a driving-low or push-pull pin
  property p_pull_low; (pin_pullup_reg & pin_oe_reg) == 17'h0; endproperty
  a_pull_low: assert property (p_pull_low) else $error("pull-up on driven pin");
  property p_pull_pp; (pin_pullup_reg & $past(port_output_mode_reg)) == 17'h0; endproperty
  a_pull_pp: assert property (p_pull_pp) else $error("pull-up on push-pull pin");
  property p_analog; (~$past(port_input_mode_reg) & (pin_oe_reg | pin_pullup_reg)) == 17'h0; endproperty
  a_analog: assert property (p_analog) else $error("analog pin driven or pulled");
  // main scenarios
  c_xbar_on: cover property ($rose(crossbar_enable_reg));
  c_rmw_read: cover property (sfr_rd && sfr_rmw);
  c_all_cmp: cover property (compare_module_route_reg == 3'h7);
endmodule // plx_port_latch_chk
bind plx_port_latch plx_port_latch_chk plx_port_latch_chk_i (.clock, .sys_rst, .sfr_addr, .sfr_rd, .sfr_rmw,
  .sfr_rdata_reg, .pin_in, .pin_oe_reg, .pin_pullup_reg, .port_output_mode_reg, .port_input_mode_reg,
  .timer1_input_route_en_reg, .timer0_input_route_en_reg, .counter_array_ext_clk_route_en_reg,
  .compare_module_route_reg, .crossbar_enable_reg);
`default_nettype wire

// ### test/plx_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************
// external pins: drivers, pull-ups, outside world
// ****************************************************
module plx_pin_model (
  input wire logic clock,
  input wire logic [16:0] pin_out_reg,
  input wire logic [16:0] pin_oe_reg,
  input wire logic [16:0] pin_pullup_reg,
  input wire logic [16:0] ext_en, // outside device drives
  input wire logic [16:0] ext_val,
  output logic [16:0] pin_in
);
  logic [16:0] float_reg; // floating pins wander, never a stale level
  initial float_reg = 17'h0aaaa;
  always @(posedge clock) begin
    float_reg <= ~float_reg;
  end
  // device driver wins, then outside driver, then pull-up
  assign pin_in = (pin_oe_reg & pin_out_reg)
    | (~pin_oe_reg & ((ext_en & ext_val) | (~ext_en & (pin_pullup_reg | float_reg))));
endmodule // plx_pin_model
`default_nettype wire

// ### test/plx_port_latch_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************
// port latch testbench
// ****************************************************
module plx_port_latch_tb;
  import plx_pkg::*;
  logic clock, sys_rst, sfr_wr, sfr_rd, sfr_bit_wdata, sfr_bit_wr, sfr_bit_rd, sfr_rmw, sfr_bit_rdata_reg;
  logic [7:0] sfr_addr, sfr_wdata, sfr_bit_addr, sfr_rdata_reg;
  logic [16:0] pin_in, pin_out_reg, pin_oe_reg, pin_pullup_reg, port_output_mode_reg, port_input_mode_reg;
  logic [16:0] periph_sel, periph_out, ext_en, ext_val;
  logic timer1_input_route_en_reg, timer0_input_route_en_reg, counter_array_ext_clk_route_en_reg;
  logic crossbar_enable_reg, weak_pullup_disable_reg;
  logic [2:0] compare_module_route_reg;
  int fail_count, checks_done, cyc;
  plx_port_latch plx_port_latch_i (.clock, .sys_rst, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd, .sfr_bit_addr,
    .sfr_bit_wdata, .sfr_bit_wr, .sfr_bit_rd, .sfr_rmw, .sfr_rdata_reg, .sfr_bit_rdata_reg, .pin_in, .pin_out_reg,
    .pin_oe_reg, .pin_pullup_reg, .port_output_mode_reg, .port_input_mode_reg, .periph_sel, .periph_out,
    .timer1_input_route_en_reg, .timer0_input_route_en_reg, .counter_array_ext_clk_route_en_reg,
    .compare_module_route_reg, .crossbar_enable_reg, .weak_pullup_disable_reg);
  plx_pin_model plx_pin_model_i (.clock, .pin_out_reg, .pin_oe_reg, .pin_pullup_reg, .ext_en, .ext_val, .pin_in);
  // ****************************************************
  // bus tasks: strobe held one cycle, data read after it
  // ****************************************************
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clock);
    sfr_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic m, input logic [7:0] e);
    @(posedge clock);
    sfr_addr <= a;
    sfr_rmw <= m;
    sfr_rd <= 1'b1;
    @(posedge clock);
    sfr_rd <= 1'b0;
    sfr_rmw <= 1'b0;
    #1 chk({9'h0, sfr_rdata_reg}, {9'h0, e});
  endtask
  task automatic bwr(input logic [7:0] a, input logic v);
    @(posedge clock);
    sfr_bit_addr <= a;
    sfr_bit_wdata <= v;
    sfr_bit_wr <= 1'b1;
    @(posedge clock);
    sfr_bit_wr <= 1'b0;
  endtask
  task automatic brd(input logic [7:0] a, input logic m, input logic e);
    @(posedge clock);
    sfr_bit_addr <= a;
    sfr_rmw <= m;
    sfr_bit_rd <= 1'b1;
    @(posedge clock);
    sfr_bit_rd <= 1'b0;
    sfr_rmw <= 1'b0;
    #1 chk({16'h0, sfr_bit_rdata_reg}, {16'h0, e});
  endtask
  // pins follow a register write one cycle on
  task automatic settle();
    repeat (3) @(posedge clock);
    #1;
  endtask
  // ****************************************************
  // scenarios
  // ****************************************************
  task automatic t_reset();
    rd(8'he2, 1'b0, 8'h00);
    rd(8'ha0, 1'b1, 8'h01);
    rd(8'h80, 1'b1, 8'hff);
    rd(8'h33, 1'b0, 8'h00);
    chk(pin_oe_reg, 17'h0);
  endtask
  task automatic t_gpio();
    wr(8'h80, 8'ha5);
    settle();
    chk(pin_oe_reg, 17'h0);
    port_output_mode_reg <= 17'h1ffff;
    wr(8'he2, 8'h40);
    settle();
    chk(pin_out_reg, 17'h1ffa5);
    chk(pin_oe_reg, 17'h1ffff);
    chk({16'h0, crossbar_enable_reg}, 17'h1);
    rd(8'h80, 1'b0, 8'ha5);
    periph_sel <= 17'h10000;
    settle();
    rd(8'ha0, 1'b0, 8'h00);
    rd(8'ha0, 1'b1, 8'h01);
    periph_sel <= 17'h0;
  endtask
  task automatic t_rmw();
    port_output_mode_reg <= 17'h0;
    ext_en <= 17'h0000f;
    wr(8'h80, 8'hff);
    settle();
    rd(8'h80, 1'b0, 8'hf0);
    rd(8'h80, 1'b1, 8'hff);
    chk(pin_pullup_reg, 17'h1ffff);
    port_input_mode_reg <= 17'h1ff7f;
    settle();
    rd(8'h80, 1'b0, 8'h70);
    chk(pin_pullup_reg, 17'h1ff7f);
    port_input_mode_reg <= 17'h1ffff;
    bwr(8'h83, 1'b0);
    brd(8'h83, 1'b1, 1'b0);
    rd(8'h80, 1'b1, 8'hf7);
    brd(8'h81, 1'b0, 1'b0);
    brd(8'h81, 1'b1, 1'b1);
    bwr(8'ha1, 1'b0);
    rd(8'ha0, 1'b1, 8'h01);
  endtask
  task automatic t_cfg();
    logic [2:0] th;
    wr(8'he2, 8'hff);
    rd(8'he2, 1'b0, 8'hfb);
    settle();
    chk(pin_pullup_reg, 17'h0);
    chk({16'h0, weak_pullup_disable_reg}, 17'h1);
    for (int s = 0; s < 4; s++) begin
      th = 3'h7 >> (3 - s);
      wr(8'he2, 8'h40 | s[7:0]);
      settle();
      chk({14'h0, compare_module_route_reg}, {14'h0, th});
      chk({15'h0, timer1_input_route_en_reg, counter_array_ext_clk_route_en_reg}, 17'h0);
    end
    wr(8'he2, 8'h70);
    settle();
    chk({15'h0, timer1_input_route_en_reg, timer0_input_route_en_reg}, 17'h3);
    wr(8'he2, 8'h48);
    settle();
    chk({15'h0, timer0_input_route_en_reg, counter_array_ext_clk_route_en_reg}, 17'h1);
    port_output_mode_reg <= 17'h1ffff;
    wr(8'he2, 8'h3b);
    settle();
    chk({13'h0, crossbar_enable_reg, timer1_input_route_en_reg, compare_module_route_reg[1:0]}, 17'h0);
    chk(pin_oe_reg, 17'h0);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ****************************************************
  // clock, watchdog and main sequence
  // ****************************************************
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // a hang counts as a mismatch, then closes the run
  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      stop_test();
    end
  end
  initial begin
    {sys_rst, sfr_addr, sfr_wdata, sfr_wr, sfr_rd, sfr_bit_addr} = {1'b1, 26'h0};
    {sfr_bit_wdata, sfr_bit_wr, sfr_bit_rd, sfr_rmw} = 4'h0;
    {port_output_mode_reg, port_input_mode_reg, periph_sel} = {17'h0, 17'h1ffff, 17'h0};
    {periph_out, ext_en, ext_val} = 51'h0;
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    t_reset();
    t_gpio();
    t_rmw();
    t_cfg();
    stop_test();
  end
endmodule // plx_port_latch_tb
`default_nettype wire
